// *** core/htd_params.svh ***
// constants for the transfer descriptor engine: field positions, codes, register offsets and timing
`ifndef HTD_PARAMS_SVH
`define HTD_PARAMS_SVH
// descriptor bit positions (64-bit descriptor, byte n at bits 8n+7:8n)
`define HTD_XFER_LO 0
`define HTD_RESULT_LO 12
`define HTD_LIVE_BIT 11
`define HTD_TOGGLE_BIT 10
`define HTD_PSL_LO 16
`define HTD_SPEED_BIT 26
`define HTD_LAST_BIT 27
`define HTD_EPI_LO 28
`define HTD_REQ_LO 32
`define HTD_TOKEN_LO 42
`define HTD_HALF_BIT 46
`define HTD_PAIRED_BIT 47
`define HTD_TDN_LO 48
`define HTD_B7_LO 56
// result codes
`define HTD_RC_OK 4'h0
`define HTD_RC_TOGGLE 4'h3
`define HTD_RC_NORESP 4'h5
`define HTD_RC_OVERRUN 4'h8
`define HTD_RC_UNDERRUN 4'h9
// register offsets
`define HTD_REG_CTRL 4'h0
`define HTD_REG_STATUS 4'h1
`define HTD_REG_IRQ_STAT 4'h2
`define HTD_REG_IRQ_CLR 4'h3
`define HTD_REG_IRQ_EN 4'h4
`define HTD_REG_WB_LO 4'h5
`define HTD_REG_WB_HI 4'h6
// timing
`define HTD_RESP_TIMEOUT_NS 16000
`define HTD_CLK_NS 10
`endif

// *** core/htd_pkg.sv ***
// types for the transfer descriptor engine
package htd_pkg;
    typedef enum logic [1:0] {HTD_ASYNC, HTD_PERIODIC, HTD_ISO} htd_list_t;
    typedef enum logic [1:0] {HTD_SETUP, HTD_OUT, HTD_IN, HTD_TOKRSV} htd_token_t;
    typedef enum {HTD_IDLE, HTD_CHECK, HTD_ISSUE, HTD_WAIT, HTD_DONE} htd_state_t;
endpackage

// *** core/htd_engine.sv ***
// transfer descriptor engine: executes one descriptor and writes back its status
//
// Operation
// - write back count of bytes actually moved in 10-bit field.
// - live flag enables execution; engine clears it on completion, skips when clear.
// - toggle selects DATA0/DATA1, checked on IN, flipped after each good packet.
// - each packet limited to packet size limit, field never modified.
// - endpoint addressed by the 4-bit endpoint index.
// - last bit marks end of iso list only; others use tail markers.
// - speed bit 0 full-speed, 1 low-speed.
// - requested byte count split into packets up to the limit.
// - paired descriptors may both be live; ping half comes first (engine enforces this order on the async list only).
// - pong payload only after ping (held back on the async list only); current half exposed.
// - function addressed by 7-bit target device number.
// - periodic byte 7 holds 3-bit poll exponent and 5-bit first frame.
// - iso descriptor runs only when byte 7 equals frame number.
// - 4-bit result code reports outcome, zero meaning no error.
// - async go starts send; live cleared and result updated once sent.
`include "htd_params.svh"
`timescale 1ns/10ps
`default_nettype none
module htd_engine
    import htd_pkg::*;
#(
    parameter int RESP_TIMEOUT = `HTD_RESP_TIMEOUT_NS / `HTD_CLK_NS
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic [63:0] descIn,
    input wire logic [7:0] frameCount,
    output logic pktReq,
    output logic [1:0] pktToken,
    output logic [6:0] pktDevice,
    output logic [3:0] pktEndpoint,
    output logic [9:0] pktLen,
    output logic pktData1,
    output logic pktLowSpeed,
    output logic pongOnBus,
    input wire logic pktDone,
    input wire logic pktAck,
    input wire logic pktData1In,
    input wire logic [9:0] pktRxLen,
    input wire logic [3:0] pktErr,
    output logic [63:0] descOut,
    output logic descWb,
    output logic listEnd,
    output logic irq
);
    // ************************************************
    // field helpers
    // ************************************************
    function automatic logic [9:0] minLen(input logic [9:0] a, input logic [9:0] b);
        minLen = (a < b) ? a : b;
    endfunction

    // ************************************************
    // registers
    // ************************************************
    htd_state_t state_q, state_d;
    logic [63:0] desc_q, desc_d;
    logic [9:0] moved_q, moved_d;
    logic [9:0] remain_q, remain_d;
    logic [15:0] timer_q, timer_d;
    logic [1:0] list_q, list_d;
    logic go_q, go_d;
    logic pingSent_q, pingSent_d;
    logic [2:0] irqStat_q, irqStat_d;
    logic [2:0] irqEn_q, irqEn_d;
    logic [31:0] rdata_q, rdata_d;
    logic pktReq_q, pktReq_d;
    logic [9:0] pktLen_q, pktLen_d;
    logic descWb_q, descWb_d;
    logic listEnd_q, listEnd_d;
    logic irq_q, irq_d;
    logic pongOnBus_q, pongOnBus_d;

    logic live, toggle, paired, half, isoLast;
    logic [9:0] limit, request;
    logic [7:0] byte7;
    logic [4:0] pollMask;
    logic due;
    logic evDone, evErr, evSkip;

    always_comb
    begin
        live = desc_q[`HTD_LIVE_BIT];
        toggle = desc_q[`HTD_TOGGLE_BIT];
        paired = desc_q[`HTD_PAIRED_BIT];
        half = desc_q[`HTD_HALF_BIT];
        isoLast = desc_q[`HTD_LAST_BIT];
        limit = desc_q[`HTD_PSL_LO +: 10];
        request = desc_q[`HTD_REQ_LO +: 10];
        byte7 = desc_q[`HTD_B7_LO +: 8];
        // periodic poll every 2^N frames from first frame, within 32-frame window
        pollMask = 5'(({5'h1f} << byte7[7:5]) & 5'h1f);
        due = 1'b1;
        unique case (list_q)
            HTD_ISO: due = (byte7 == frameCount);
            HTD_PERIODIC: due = (((frameCount[4:0] ^ byte7[4:0]) & ~pollMask) == 5'h00);
            default: due = 1'b1;
        endcase
    end

    always_comb
    begin
        state_d = state_q;
        desc_d = desc_q;
        moved_d = moved_q;
        remain_d = remain_q;
        timer_d = timer_q;
        list_d = list_q;
        go_d = go_q;
        pingSent_d = pingSent_q;
        pktReq_d = 1'b0;
        pktLen_d = pktLen_q;
        descWb_d = 1'b0;
        listEnd_d = listEnd_q;
        evDone = 1'b0;
        evErr = 1'b0;
        evSkip = 1'b0;
        irqEn_d = irqEn_q;
        rdata_d = 32'h0000_0000;
        if (regWrite && regAddr == `HTD_REG_CTRL)
        begin
            go_d = regWdata[0];
            list_d = regWdata[2:1];
        end
        if (regWrite && regAddr == `HTD_REG_IRQ_EN)
            irqEn_d = regWdata[2:0];
        unique case (state_q)
            HTD_IDLE:
            begin
                if (go_q)
                begin
                    desc_d = descIn;
                    listEnd_d = 1'b0;
                    state_d = HTD_CHECK;
                end
            end
            HTD_CHECK:
            begin
                moved_d = 10'h000;
                remain_d = request;
                if (!live || !due)
                begin
                    evSkip = !live;
                    state_d = HTD_DONE;
                end
                else if (list_q == HTD_ASYNC && paired && half && !pingSent_q)
                    state_d = HTD_DONE;
                else
                    state_d = HTD_ISSUE;
            end
            HTD_ISSUE:
            begin
                pktLen_d = minLen(remain_q, limit);
                pktReq_d = 1'b1;
                timer_d = 16'(RESP_TIMEOUT);
                state_d = HTD_WAIT;
            end
            HTD_WAIT:
            begin
                timer_d = timer_q - 16'h0001;
                if (pktDone || timer_q == 16'h0000)
                begin
                    if (!pktDone)
                        desc_d[`HTD_RESULT_LO +: 4] = `HTD_RC_NORESP;
                    else if (desc_q[`HTD_TOKEN_LO +: 2] == HTD_IN && pktData1In != toggle)
                        desc_d[`HTD_RESULT_LO +: 4] = `HTD_RC_TOGGLE;
                    else if (pktErr != `HTD_RC_OK)
                        desc_d[`HTD_RESULT_LO +: 4] = pktErr;
                    else if (desc_q[`HTD_TOKEN_LO +: 2] == HTD_IN && pktRxLen > pktLen_q)
                        desc_d[`HTD_RESULT_LO +: 4] = `HTD_RC_OVERRUN;
                    else
                        desc_d[`HTD_RESULT_LO +: 4] = `HTD_RC_OK;
                    if (pktDone && pktAck && desc_d[`HTD_RESULT_LO +: 4] == `HTD_RC_OK)
                    begin
                        desc_d[`HTD_TOGGLE_BIT] = ~toggle;
                        if (desc_q[`HTD_TOKEN_LO +: 2] == HTD_IN)
                        begin
                            moved_d = moved_q + pktRxLen;
                            remain_d = remain_q - pktRxLen;
                        end
                        else
                        begin
                            moved_d = moved_q + pktLen_q;
                            remain_d = remain_q - pktLen_q;
                        end
                        // short IN packet ends the transfer
                        if (remain_d != 10'h000 &&
                            !(desc_q[`HTD_TOKEN_LO +: 2] == HTD_IN && pktRxLen < pktLen_q))
                            state_d = HTD_ISSUE;
                        else
                            state_d = HTD_DONE;
                    end
                    else
                    begin
                        evErr = 1'b1;
                        state_d = HTD_DONE;
                    end
                    if (state_d == HTD_DONE)
                    begin
                        desc_d[`HTD_LIVE_BIT] = 1'b0;
                        desc_d[`HTD_XFER_LO +: 10] = moved_d;
                        descWb_d = 1'b1;
                        evDone = 1'b1;
                        if (list_q == HTD_ASYNC && paired)
                            pingSent_d = !half;
                    end
                end
            end
            HTD_DONE:
            begin
                listEnd_d = (list_q == HTD_ISO) && isoLast;
                go_d = 1'b0;
                state_d = HTD_IDLE;
            end
            default: state_d = HTD_IDLE;
        endcase
        // sticky events; set beats a same-cycle clear
        irqStat_d = irqStat_q;
        if (regWrite && regAddr == `HTD_REG_IRQ_CLR)
            irqStat_d = irqStat_q & ~regWdata[2:0];
        irqStat_d = irqStat_d | {evSkip, evErr, evDone};
        irq_d = |(irqStat_d & irqEn_d);
        pongOnBus_d = desc_d[`HTD_PAIRED_BIT] & desc_d[`HTD_HALF_BIT];
        if (regRead)
        begin
            unique case (regAddr)
                `HTD_REG_CTRL: rdata_d = {29'h0, list_q, go_q};
                `HTD_REG_STATUS: rdata_d = {26'h0, listEnd_q, pingSent_q, half,
                                            state_q == HTD_IDLE, 2'h0};
                `HTD_REG_IRQ_STAT: rdata_d = {29'h0, irqStat_q};
                `HTD_REG_IRQ_EN: rdata_d = {29'h0, irqEn_q};
                `HTD_REG_WB_LO: rdata_d = desc_q[31:0];
                `HTD_REG_WB_HI: rdata_d = desc_q[63:32];
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= HTD_IDLE;
            desc_q <= 64'h0;
            moved_q <= 10'h000;
            remain_q <= 10'h000;
            timer_q <= 16'h0000;
            list_q <= 2'h0;
            go_q <= 1'b0;
            pingSent_q <= 1'b0;
            irqStat_q <= 3'h0;
            irqEn_q <= 3'h0;
            rdata_q <= 32'h0000_0000;
            pktReq_q <= 1'b0;
            pktLen_q <= 10'h000;
            descWb_q <= 1'b0;
            listEnd_q <= 1'b0;
            irq_q <= 1'b0;
            pongOnBus_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            desc_q <= desc_d;
            moved_q <= moved_d;
            remain_q <= remain_d;
            timer_q <= timer_d;
            list_q <= list_d;
            go_q <= go_d;
            pingSent_q <= pingSent_d;
            irqStat_q <= irqStat_d;
            irqEn_q <= irqEn_d;
            rdata_q <= rdata_d;
            pktReq_q <= pktReq_d;
            pktLen_q <= pktLen_d;
            descWb_q <= descWb_d;
            listEnd_q <= listEnd_d;
            irq_q <= irq_d;
            pongOnBus_q <= pongOnBus_d;
        end
    end

    // ************************************************
    // outputs, all from flip-flops
    // ************************************************
    assign regRdata = rdata_q;
    assign pktReq = pktReq_q;
    assign pktLen = pktLen_q;
    assign pktToken = desc_q[`HTD_TOKEN_LO +: 2];
    assign pktDevice = desc_q[`HTD_TDN_LO +: 7];
    assign pktEndpoint = desc_q[`HTD_EPI_LO +: 4];
    assign pktData1 = desc_q[`HTD_TOGGLE_BIT];
    assign pktLowSpeed = desc_q[`HTD_SPEED_BIT];
    // current half on bus; half only meaningful when paired
    assign pongOnBus = pongOnBus_q;
    assign descOut = desc_q;
    assign descWb = descWb_q;
    assign listEnd = listEnd_q;
    assign irq = irq_q;
endmodule
`default_nettype wire

// *** verif/htd_checker.sv ***
// port assertions for the transfer descriptor engine
`timescale 1ns/10ps
`default_nettype none
module htd_checker #(
    parameter int RESP_TIMEOUT = 1600
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic [63:0] descIn,
    input wire logic pktReq,
    input wire logic [6:0] pktDevice,
    input wire logic [3:0] pktEndpoint,
    input wire logic [9:0] pktLen,
    input wire logic pktLowSpeed,
    input wire logic [63:0] descOut,
    input wire logic descWb
);
    // ********
    // checks
    // ********
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RD_IDLE: assert property (!$past(regRead) |-> regRdata == 32'h0)
        else $error("read data not zero outside the answer cycle");
    AST_REQ_ONE: assert property (pktReq |=> !pktReq)
        else $error("packet request longer than one cycle");
    AST_LEN: assert property (pktReq |-> pktLen <= descIn[25:16] && pktLen <= descIn[41:32])
        else $error("packet length above limit");
    AST_DEV: assert property (pktReq |-> pktDevice == descIn[54:48])
        else $error("wrong device number");
    AST_EP: assert property (pktReq |-> pktEndpoint == descIn[31:28])
        else $error("wrong endpoint index");
    AST_SPEED: assert property (pktReq |-> pktLowSpeed == descIn[26])
        else $error("wrong speed");
    AST_LIVE_REQ: assert property (pktReq |-> descIn[11])
        else $error("packet issued for a descriptor that is not live");
    AST_WB_KEEP: assert property (descWb |-> descOut[63:16] == descIn[63:16])
        else $error("write back changed a firmware field");
    AST_WB_LIVE: assert property (descWb |-> !descOut[11])
        else $error("live flag not cleared on write back");
    AST_WB_COUNT: assert property (descWb && descOut[15:12] == 4'h0 |->
        descOut[9:0] == descIn[41:32])
        else $error("transferred count differs from request");
endmodule
bind htd_engine htd_checker #(.RESP_TIMEOUT(RESP_TIMEOUT)) i_chk (.clk(clk), .rst_n(rst_n),
    .regRead(regRead), .regRdata(regRdata), .descIn(descIn), .pktReq(pktReq),
    .pktDevice(pktDevice), .pktEndpoint(pktEndpoint), .pktLen(pktLen),
    .pktLowSpeed(pktLowSpeed), .descOut(descOut), .descWb(descWb));
`default_nettype wire

// *** verif/htd_link_model.sv ***
// far-side endpoint model answering packet requests
`timescale 1ns/10ps
`default_nettype none
module htd_link_model
    import htd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pktReq,
    input wire logic [1:0] pktToken,
    input wire logic [9:0] pktLen,
    input wire logic pktData1,
    input wire logic [31:0] respDelay,
    input wire logic mute,
    input wire logic badTog,
    output logic pktDone,
    output logic pktAck,
    output logic pktData1In,
    output logic [9:0] pktRxLen,
    output logic [3:0] pktErr
);
    int cnt;
    logic busy;
    logic isIn;
    logic d1;
    logic [9:0] len;
    // ********
    // answer
    // ********
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
            pktDone <= 1'b0;
            pktAck <= 1'b0;
            pktData1In <= 1'b0;
            pktRxLen <= 10'h0;
            pktErr <= 4'h0;
        end
        else
        begin
            // idle lines wander, never hold the last answer
            pktDone <= 1'b0;
            pktAck <= ~pktAck;
            pktData1In <= ~pktData1In;
            pktRxLen <= ~pktRxLen;
            pktErr <= ~pktErr;
            if (pktReq && !mute)
            begin
                busy <= 1'b1;
                cnt <= respDelay;
                isIn <= (pktToken == HTD_IN);
                d1 <= pktData1;
                len <= pktLen;
            end
            else if (busy && cnt == 0)
            begin
                busy <= 1'b0;
                pktDone <= 1'b1;
                pktAck <= 1'b1;
                pktErr <= 4'h0;
                pktData1In <= d1 ^ badTog;
                pktRxLen <= isIn ? len : 10'h0;
            end
            else if (busy)
                cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking testbench for the transfer descriptor engine
`include "htd_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tb
    import htd_pkg::*;
;
    logic clk, rst_n, regWrite, regRead, pktReq, pktData1, pktLowSpeed, descWb, listEnd, irq;
    logic pktDone, pktAck, pktData1In, mute, badTog, pongOnBus;
    logic [3:0] regAddr, pktEndpoint, pktErr;
    logic [31:0] regWdata, regRdata, rdv;
    logic [63:0] descIn, descOut;
    logic [7:0] frameCount;
    logic [1:0] pktToken;
    logic [6:0] pktDevice;
    logic [9:0] pktLen, pktRxLen;
    int n_mismatch, checks_done, respDelay, k;
    htd_engine #(.RESP_TIMEOUT(20)) i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .descIn(descIn), .frameCount(frameCount), .pktReq(pktReq), .pktToken(pktToken),
        .pktDevice(pktDevice), .pktEndpoint(pktEndpoint), .pktLen(pktLen), .pktData1(pktData1),
        .pktLowSpeed(pktLowSpeed), .pongOnBus(pongOnBus), .pktDone(pktDone), .pktAck(pktAck),
        .pktData1In(pktData1In), .pktRxLen(pktRxLen), .pktErr(pktErr), .descOut(descOut),
        .descWb(descWb), .listEnd(listEnd), .irq(irq));
    htd_link_model i_link (.clk(clk), .rst_n(rst_n), .pktReq(pktReq), .pktToken(pktToken),
        .pktLen(pktLen), .pktData1(pktData1), .respDelay(respDelay), .mute(mute),
        .badTog(badTog), .pktDone(pktDone), .pktAck(pktAck), .pktData1In(pktData1In),
        .pktRxLen(pktRxLen), .pktErr(pktErr));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ********
    // tasks
    // ********
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        rdv = regRdata;
    endtask
    // reserved bits zero, legal token only
    function automatic logic [63:0] mk(input logic [9:0] lim, input logic [9:0] req,
        input logic [1:0] tok, input logic tog, input logic live, input logic last,
        input logic [7:0] b7);
        mk = {b7, 8'h5a, 4'h0, tok, req, 4'ha, last, 1'b1, lim, 4'hf, live, tog, 10'h0};
    endfunction
    // packet lengths on the fly, then the written-back descriptor
    task automatic run(input logic [2:0] ctl, input logic [63:0] d, input logic [15:0] exp,
        input logic [15:0] m);
        int rem;
        int n;
        rem = d[41:32];
        n = 0;
        descIn <= d;
        wr(`HTD_REG_CTRL, {29'h0, ctl});
        while (descWb !== 1'b1 && n < 4000)
        begin
            @(posedge clk);
            #1;
            n++;
            if (pktReq === 1'b1)
            begin
                chk("pktLen", (rem < d[25:16]) ? rem : d[25:16], pktLen);
                rem = rem - d[25:16];
            end
        end
        if (n >= 4000)
        begin
            n_mismatch++;
            results();
        end
        chk("wb status", exp & m, descOut[15:0] & m);
        chk("wb fields", d[63:16], descOut[63:16]);
        // let the closing state pass so level outputs have settled
        @(posedge clk);
        #1;
    endtask
    // frame, poll or pairing gate holds the descriptor: no event at all
    task automatic held(input string nm, input logic [2:0] ctl, input logic [63:0] d);
        descIn <= d;
        wr(`HTD_REG_IRQ_CLR, 32'h7);
        wr(`HTD_REG_CTRL, {29'h0, ctl});
        repeat (20) @(posedge clk);
        rd(`HTD_REG_IRQ_STAT);
        chk(nm, 32'h0, rdv & 32'h7);
    endtask
    // ********
    // sequence
    // ********
    initial
    begin
        {rst_n, regWrite, regRead, mute, badTog, regAddr, regWdata, descIn} = '0;
        frameCount = 8'h05;
        respDelay = 0;
        n_mismatch = 0;
        checks_done = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`HTD_REG_STATUS);
        chk("idle", 32'h4, rdv & 32'h4);
        rd(4'hf);
        chk("unmapped", 32'h0, rdv);
        wr(`HTD_REG_IRQ_EN, 32'h7);
        run(3'b001, mk(10'h8, 10'h14, HTD_OUT, 1'b0, 1'b1, 1'b0, 8'h0), 16'h0414, 16'hffff);
        chk("irq", 1'b1, irq);
        chk("listEnd", 1'b0, listEnd);
        wr(`HTD_REG_IRQ_CLR, 32'h7);
        rd(`HTD_REG_IRQ_STAT);
        chk("stat clr", 32'h0, rdv & 32'h7);
        chk("irq clr", 1'b0, irq);
        respDelay = 5;
        run(3'b011, mk(10'h10, 10'h10, HTD_IN, 1'b1, 1'b1, 1'b0, 8'h21), 16'h0010,
            16'hffff);
        run(3'b101, mk(10'h0a, 10'h0a, HTD_OUT, 1'b0, 1'b1, 1'b1, 8'h05), 16'h040a,
            16'hffff);
        chk("listEnd", 1'b1, listEnd);
        held("iso frame", 3'b101, mk(10'h0a, 10'h0a, HTD_OUT, 1'b0, 1'b1, 1'b0, 8'h06));
        held("poll due", 3'b011, mk(10'h10, 10'h10, HTD_IN, 1'b1, 1'b1, 1'b0, 8'h20));
        run(3'b001, mk(10'h8, 10'h8, HTD_OUT, 1'b0, 1'b1, 1'b0, 8'h0) ^ 64'h0000_8000_0400_0000,
            16'h0408, 16'hffff);
        chk("ping bus", 1'b0, pongOnBus);
        rd(`HTD_REG_STATUS);
        chk("ping sent", 32'h10, rdv & 32'h18);
        run(3'b001, mk(10'h8, 10'h8, HTD_OUT, 1'b1, 1'b1, 1'b0, 8'h0) ^ 64'h0000_c000_0000_0000,
            16'h0008, 16'hffff);
        chk("pong bus", 1'b1, pongOnBus);
        held("pong first", 3'b001, mk(10'h8, 10'h8, HTD_OUT, 1'b1, 1'b1, 1'b0, 8'h0) ^
            64'h0000_c000_0000_0000);
        wr(`HTD_REG_IRQ_CLR, 32'h7);
        descIn <= mk(10'h8, 10'h8, HTD_OUT, 1'b0, 1'b0, 1'b0, 8'h0);
        wr(`HTD_REG_CTRL, 32'h1);
        rdv = '0;
        for (k = 0; k < 100 && rdv[2] !== 1'b1; k++)
            rd(`HTD_REG_IRQ_STAT);
        chk("skipped", 32'h4, rdv & 32'h7);
        if (k == 100)
            results();
        wr(`HTD_REG_IRQ_CLR, 32'h7);
        badTog = 1'b1;
        run(3'b001, mk(10'h8, 10'h10, HTD_IN, 1'b0, 1'b1, 1'b0, 8'h0), 16'h3000, 16'hffff);
        badTog = 1'b0;
        mute = 1'b1;
        run(3'b001, mk(10'h8, 10'h8, HTD_OUT, 1'b0, 1'b1, 1'b0, 8'h0), 16'h5000, 16'hffff);
        rd(`HTD_REG_IRQ_STAT);
        chk("error", 32'h2, rdv & 32'h2);
        results();
    end
endmodule
`default_nettype wire
